// [src/lmon_monitor.sv]
// serial-bus slave register bank for a four-string led driver monitor
// assumes conversions and open detect come from logic on sys_clk;
// scl, sda and the strap are pins and are synchronised here
`timescale 1ns/100ps
`include "lmon_regs.svh"

// Behaviour
// R1: address lsb one reads, zero writes
// R2: ack slot low acks, high nacks
// R3: transfers follow smbus two-wire protocol
// R4: drain registers at 00h through 03h
// R5: drain code unsigned eight bits, 8V
// R6: anode register at 04h, read-only
// R7: anode code unsigned eight bits, 67.9V
// R8: strings one, two status at 05h
// R9: strings three, four 06h; faults 07h
// R10: host writes unused bits 7, 6
// R11: unused string excluded from fault reporting
// R12: ack sent after mask applied
// R13: host ignores faults until unused acked
// R14: over-voltage flag above 6.75V drain
// R15: open flag set when string open
// R16: unused status bit mirrors mask
// R17: 05h resets zero, top bits writable
// R18: host cuts pwm duty on short
// R19: bus writes leave read-only registers
// R20: address mismatch ignored until next start
// R21: strap picks one of three addresses
// R22: first data byte selects register
// R23: writes to read-only registers acked, dropped
module lmon_monitor (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe,
  input  wire logic [1:0]        strap_i,
  input  wire lmon_pkg::lmon_meas_s meas_i,
  input  wire logic [3:0]        string_open_i,
  input  wire logic [7:0]        fault_reg_i,
  output logic                   fault_flag_output
);
  lmon_pkg::lmon_state_e state_q, state_d;
  lmon_pkg::lmon_state_e after_q, after_d;
  logic [3:0] sync1_q, sync2_q;
  logic       scl_prev_q, sda_prev_q;
  logic       scl_s, sda_s;
  logic       scl_rise, scl_fall;
  logic       start_w, stop_w;
  logic [1:0] strap_cnt_q, strap_cnt_d;
  logic       strap_done_q, strap_done_d;
  logic [6:0] addr_q, addr_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] ptr_q, ptr_d;
  logic       mack_q, mack_d;
  logic       oe_q, oe_d;
  logic [3:0] mask_q, mask_d;
  logic       flag_q, flag_d;
  logic [7:0] stat_a, stat_b, rd_byte;

  // scl, sda, strap pins each pass two flops
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync1_q    <= 4'h3;
      sync2_q    <= 4'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      sync1_q    <= {strap_i, sda_i, scl_i};
      sync2_q    <= sync1_q;
      scl_prev_q <= sync2_q[0];
      sda_prev_q <= sync2_q[1];
    end
  end
  assign scl_s    = sync2_q[0];
  assign sda_s    = sync2_q[1];
  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  // R3: start and stop framing
  assign start_w  = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_w   = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  // R21: strap caught once synchronisers settle
  always_comb begin
    strap_cnt_d  = strap_cnt_q;
    strap_done_d = strap_done_q;
    addr_d       = addr_q;
    if (!strap_done_q) begin
      strap_cnt_d = strap_cnt_q + 2'h1;
      if (strap_cnt_q == `LMON_STRAP_WAIT) begin
        strap_done_d = 1'b1;
        addr_d = (sync2_q[3:2] == `LMON_STRAP_GND)  ? `LMON_ADDR_GND  :
                 (sync2_q[3:2] == `LMON_STRAP_OPEN) ? `LMON_ADDR_OPEN : `LMON_ADDR_VDD;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      strap_cnt_q  <= 2'h0;
      strap_done_q <= 1'b0;
      addr_q       <= `LMON_ADDR_GND;
    end else begin
      strap_cnt_q  <= strap_cnt_d;
      strap_done_q <= strap_done_d;
      addr_q       <= addr_d;
    end
  end
  function automatic logic [2:0] lmon_flags(logic [7:0] drain, logic open, logic unused);
    // R11: masked string never flags a fault
    // R14: over-voltage above threshold code
    // R15: open flag follows detector
    // R16: unused bit mirrors mask
    return {~unused & (drain > `LMON_OV_CODE), ~unused & open, unused};
  endfunction
  // R8: pair a layout, mask bits on top
  assign stat_a = {mask_q[0], mask_q[1],
                   lmon_flags(meas_i.drain[0], string_open_i[0], mask_q[0]),
                   lmon_flags(meas_i.drain[1], string_open_i[1], mask_q[1])};
  // R9: pair b mirrors pair a
  assign stat_b = {mask_q[2], mask_q[3],
                   lmon_flags(meas_i.drain[2], string_open_i[2], mask_q[2]),
                   lmon_flags(meas_i.drain[3], string_open_i[3], mask_q[3])};
  // R22: pointer selects read source
  always_comb begin
    rd_byte = `LMON_UNMAPPED;
    // R4: four drain registers
    // R5: raw eight-bit drain code
    if (ptr_q <= `LMON_REG_DRAIN3) begin
      rd_byte = meas_i.drain[ptr_q[1:0]];
    end else if (ptr_q == `LMON_REG_ANODE) begin
      // R6: anode code
      // R7: raw eight-bit anode code
      rd_byte = meas_i.anode;
    end else if (ptr_q == `LMON_REG_PAIR_A) begin
      rd_byte = stat_a;
    end else if (ptr_q == `LMON_REG_PAIR_B) begin
      rd_byte = stat_b;
    end else if (ptr_q == `LMON_REG_FAULTS) begin
      // R9: faults passed through read-only
      rd_byte = fault_reg_i;
    end
  end

  always_comb begin
    state_d = state_q;
    after_d = after_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    ptr_d   = ptr_q;
    mack_d  = mack_q;
    oe_d    = oe_q;
    mask_d  = mask_q;
    if (stop_w) begin
      state_d = lmon_pkg::LMON_IDLE;
      oe_d    = 1'b0;
    end else if (start_w && strap_done_q) begin
      // R20: every start after the strap is latched re-arms address match
      state_d = lmon_pkg::LMON_ADDR;
      cnt_d   = 4'h0;
      oe_d    = 1'b0;
    end else begin
      unique case (state_q)
        lmon_pkg::LMON_IDLE: oe_d = 1'b0;
        lmon_pkg::LMON_ADDR, lmon_pkg::LMON_CMD, lmon_pkg::LMON_WR: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == `LMON_BITS) begin
            // R2: receiver pulls ack low
            state_d = lmon_pkg::LMON_ACK;
            oe_d    = 1'b1;
            cnt_d   = 4'h0;
            after_d = lmon_pkg::LMON_WR;
            if (state_q == lmon_pkg::LMON_ADDR) begin
              // R1: direction from address lsb
              after_d = sh_q[`LMON_RD_BIT] ? lmon_pkg::LMON_RD : lmon_pkg::LMON_CMD;
              // R20: mismatch drops to idle, no ack
              if (sh_q[7:1] != addr_q) begin
                state_d = lmon_pkg::LMON_IDLE;
                oe_d    = 1'b0;
              end
            end else if (state_q == lmon_pkg::LMON_CMD) begin
              // R22: first data byte is pointer
              ptr_d = sh_q;
            end else begin
              // R10: unused bits latch from host
              // R12: mask lands with ack drive
              if (ptr_q == `LMON_REG_PAIR_A) begin
                mask_d[1:0] = {sh_q[`LMON_UNUSED_LO], sh_q[`LMON_UNUSED_HI]};
              end else if (ptr_q == `LMON_REG_PAIR_B) begin
                mask_d[3:2] = {sh_q[`LMON_UNUSED_LO], sh_q[`LMON_UNUSED_HI]};
              end
              // R19: read-only bits never stored
              // R23: other writes acked, dropped
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
        lmon_pkg::LMON_ACK: begin
          if (scl_fall) begin
            oe_d    = 1'b0;
            cnt_d   = 4'h0;
            state_d = after_q;
            if (after_q == lmon_pkg::LMON_RD) begin
              sh_d = rd_byte;
              oe_d = ~rd_byte[7];
            end
          end
        end
        lmon_pkg::LMON_RD: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == `LMON_BITS) begin
              oe_d    = 1'b0;
              ptr_d   = ptr_q + 8'h01;
              state_d = lmon_pkg::LMON_RACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
            end
          end
        end
        lmon_pkg::LMON_RACK: begin
          // R2: master ack low continues read
          if (scl_rise) begin
            mack_d = ~sda_s;
          end else if (scl_fall) begin
            cnt_d = 4'h0;
            if (mack_q) begin
              state_d = lmon_pkg::LMON_RD;
              sh_d    = rd_byte;
              oe_d    = ~rd_byte[7];
            end else begin
              state_d = lmon_pkg::LMON_IDLE;
            end
          end
        end
      endcase
    end
    // R11: fault pin ignores masked strings
    flag_d = |{stat_a[5:4], stat_a[2:1], stat_b[5:4], stat_b[2:1]};
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= lmon_pkg::LMON_IDLE;
      after_q <= lmon_pkg::LMON_IDLE;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      ptr_q   <= 8'h00;
      mack_q  <= 1'b0;
      oe_q    <= 1'b0;
      // R17: unused bits clear at reset
      mask_q  <= `LMON_MASK_RST;
      flag_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      after_q <= after_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      ptr_q   <= ptr_d;
      mack_q  <= mack_d;
      oe_q    <= oe_d;
      mask_q  <= mask_d;
      flag_q  <= flag_d;
    end
  end

  // open drain: only ever pulls low
  assign sda_o             = 1'b0;
  assign sda_oe            = oe_q;
  assign fault_flag_output = flag_q;

  property p_rd_dir;
    @(posedge sys_clk) disable iff (reset)
    (state_q == lmon_pkg::LMON_ACK && scl_fall && after_q == lmon_pkg::LMON_RD)
    |=> state_q == lmon_pkg::LMON_RD && sh_q == $past(rd_byte);
  endproperty
  a_rd_dir: assert property (p_rd_dir) else $error("read not started after ack"); // R1
  property p_ack_low;
    @(posedge sys_clk) disable iff (reset)
    $rose(state_q == lmon_pkg::LMON_ACK) |-> sda_oe ##1 sda_oe;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack slot not driven low"); // R2
  property p_drain0;
    @(posedge sys_clk) disable iff (reset)
    (state_q == lmon_pkg::LMON_ACK && scl_fall && after_q == lmon_pkg::LMON_RD &&
     ptr_q == `LMON_REG_DRAIN0) |=> sh_q == $past(meas_i.drain[0]);
  endproperty
  a_drain0: assert property (p_drain0) else $error("drain 0 read mismatch"); // R4
  property p_anode;
    @(posedge sys_clk) disable iff (reset)
    (state_q == lmon_pkg::LMON_ACK && scl_fall && after_q == lmon_pkg::LMON_RD &&
     ptr_q == `LMON_REG_ANODE) |=> sh_q == $past(meas_i.anode);
  endproperty
  a_anode: assert property (p_anode) else $error("anode read mismatch"); // R6
  property p_mask_wr;
    @(posedge sys_clk) disable iff (reset)
    (state_q == lmon_pkg::LMON_WR && scl_fall && cnt_q == `LMON_BITS &&
     ptr_q == `LMON_REG_PAIR_A && !start_w && !stop_w)
    |=> mask_q[1:0] == {$past(sh_q[6]), $past(sh_q[7])} && sda_oe;
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask not applied with ack"); // R12
  property p_masked;
    @(posedge sys_clk) disable iff (reset)
    mask_q[0] |-> !stat_a[5] && !stat_a[4] && stat_a[3];
  endproperty
  a_masked: assert property (p_masked) else $error("masked string reports fault"); // R11
  property p_ov;
    @(posedge sys_clk) disable iff (reset)
    (!mask_q[0] && meas_i.drain[0] > `LMON_OV_CODE) |-> stat_a[5] ##1 fault_flag_output;
  endproperty
  a_ov: assert property (p_ov) else $error("over-voltage not flagged"); // R14
  property p_rst;
    @(posedge sys_clk)
    $past(reset) |-> mask_q == `LMON_MASK_RST && !sda_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("status not cleared by reset"); // R17
  property p_nomatch;
    @(posedge sys_clk) disable iff (reset)
    (state_q == lmon_pkg::LMON_ADDR && scl_fall && cnt_q == `LMON_BITS &&
     sh_q[7:1] != addr_q && !start_w && !stop_w)
    |=> state_q == lmon_pkg::LMON_IDLE && !sda_oe;
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("foreign address answered"); // R20
  property p_strap;
    @(posedge sys_clk) disable iff (reset)
    $rose(strap_done_q) && $past(sync2_q[3:2]) == `LMON_STRAP_GND
    |-> addr_q == `LMON_ADDR_GND;
  endproperty
  a_strap: assert property (p_strap) else $error("strap address wrong"); // R21
endmodule

// [src/lmon_regs.svh]
// register map, field positions, reset values and counts for the monitor bank
// assumes a single sys_clk domain; included by bare name
`ifndef LMON_REGS_SVH
`define LMON_REGS_SVH
`define LMON_REG_DRAIN0   8'h00
`define LMON_REG_DRAIN3   8'h03
`define LMON_REG_ANODE    8'h04
`define LMON_REG_PAIR_A   8'h05
`define LMON_REG_PAIR_B   8'h06
`define LMON_REG_FAULTS   8'h07
`define LMON_ADDR_GND     7'h2c
`define LMON_ADDR_OPEN    7'h2e
`define LMON_ADDR_VDD     7'h2f
`define LMON_STRAP_GND    2'b00
`define LMON_STRAP_OPEN   2'b01
`define LMON_MASK_RST     4'h0
`define LMON_OV_CODE      8'hd8
`define LMON_BITS         4'h8
`define LMON_STRAP_WAIT   2'h3
`define LMON_UNMAPPED     8'h00
`define LMON_RD_BIT       0
`define LMON_UNUSED_HI    7
`define LMON_UNUSED_LO    6
`endif

// [src/lmon_pkg.sv]
// types shared by the string monitor register bank
// no assumptions beyond a SystemVerilog tool
package lmon_pkg;
  typedef enum logic [2:0] {
    LMON_IDLE, LMON_ADDR, LMON_CMD, LMON_WR, LMON_ACK, LMON_RD, LMON_RACK
  } lmon_state_e;
  typedef struct packed {
    logic [3:0][7:0] drain;
    logic [7:0]      anode;
  } lmon_meas_s;
endpackage

// [dv/lmon_host.sv]
// bus host model driving scl and the open-drain sda of the monitor
// assumes sys_clk of 8 ns; one bus quarter is two sys_clk, a bit is 64 ns
`timescale 1ns/100ps
module lmon_host (
  input  wire logic sys_clk,
  input  wire logic sda_oe,
  input  wire logic sda_o,
  input  wire logic flag_i,
  output logic      scl,
  output wire logic sda
);
  logic drv_q;
  logic flag_at_ack;
  assign sda = drv_q & (~sda_oe | sda_o);
  initial begin
    scl = 1'b1;
    drv_q = 1'b1;
    flag_at_ack = 1'b0;
  end
  task automatic q();
    repeat (2) @(negedge sys_clk);
  endtask
  // start; long lead so a late slave release never looks like a stop
  task automatic start();
    drv_q = 1'b1;
    repeat (3) q();
    scl = 1'b1;
    q();
    drv_q = 1'b0;
    q();
    scl = 1'b0;
  endtask
  // stop, sda rises while scl high
  task automatic stop();
    q();
    drv_q = 1'b0;
    q();
    scl = 1'b1;
    q();
    drv_q = 1'b1;
    q();
  endtask
  // ninth bit is the ack slot, msb first
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      q();
      drv_q = d[i];
      q();
      scl = 1'b1;
      q();
      r[i] = sda;
      flag_at_ack = flag_i;
      q();
      scl = 1'b0;
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                    output logic [2:0] ack);
    logic [8:0] r0, r1, r2;
    start();
    xfer({a, 1'b0, 1'b1}, r0);
    xfer({c, 1'b1}, r1);
    xfer({d, 1'b1}, r2);
    stop();
    ack = {r0[0], r1[0], r2[0]};
  endtask
  // address lsb 1 reads; host nacks the single byte
  task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [7:0] d);
    logic [8:0] r;
    start();
    xfer({a, 1'b0, 1'b1}, r);
    xfer({c, 1'b1}, r);
    start();
    xfer({a, 1'b1, 1'b1}, r);
    xfer(9'h1ff, r);
    stop();
    d = r[8:1];
  endtask
  // host acks the first read byte, nacks the second
  task automatic rdw(input logic [6:0] a, input logic [7:0] c, output logic [15:0] d);
    logic [8:0] r, r2;
    start();
    xfer({a, 1'b0, 1'b1}, r);
    xfer({c, 1'b1}, r);
    start();
    xfer({a, 1'b1, 1'b1}, r);
    xfer(9'h1fe, r);
    xfer(9'h1ff, r2);
    stop();
    d = {r[8:1], r2[8:1]};
  endtask
  // two data bytes land in consecutive registers
  task automatic wr2(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d0,
                     input logic [7:0] d1, output logic [3:0] ack);
    logic [8:0] r0, r1, r2, r3;
    start();
    xfer({a, 1'b0, 1'b1}, r0);
    xfer({c, 1'b1}, r1);
    xfer({d0, 1'b1}, r2);
    xfer({d1, 1'b1}, r3);
    stop();
    ack = {r0[0], r1[0], r2[0], r3[0]};
  endtask
endmodule

// [dv/lmon_monitor_tb.sv]
// self-checking bench for the string monitor register bank
// assumes lmon_host as the bus host; inputs change on falling sys_clk
`timescale 1ns/100ps
module lmon_monitor_tb;
  logic                 sys_clk       = 1'b0;
  logic                 reset         = 1'b1;
  logic [1:0]           strap_i       = 2'b00;
  lmon_pkg::lmon_meas_s meas_i        = '0;
  logic [3:0]           string_open_i = 4'h0;
  logic [7:0]           fault_reg_i   = 8'h5a;
  logic                 sda_oe;
  logic                 sda_o;
  logic                 flag;
  logic                 scl;
  wire logic            sda;
  int                   err_count     = 0;
  int                   check_count   = 0;
  logic [2:0]           ack;
  logic [7:0]           d;
  always #4 sys_clk = ~sys_clk;
  lmon_monitor dut_u (.sys_clk(sys_clk), .reset(reset), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .strap_i(strap_i), .meas_i(meas_i), .string_open_i(string_open_i),
    .fault_reg_i(fault_reg_i), .fault_flag_output(flag));
  lmon_host host_u (.sys_clk(sys_clk), .sda_oe(sda_oe), .sda_o(sda_o), .flag_i(flag),
    .scl(scl), .sda(sda));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // strap is latched a few edges after release, so idle before traffic
  task automatic do_reset();
    reset = 1'b1;
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic t_reset();
    chk({7'h0, flag}, 8'h00);
    host_u.rd(7'h2c, 8'h05, d);
    chk(d, 8'h00);
  endtask
  task automatic t_meas();
    logic [8:0][7:0] e;
    e = {8'h00, 8'h5a, 8'h00, 8'h00, 8'hc3, 8'h18, 8'h24, 8'h42, 8'h81};
    meas_i = {8'h18, 8'h24, 8'h42, 8'h81, 8'hc3};
    for (int i = 0; i < 9; i++) begin
      host_u.rd(7'h2c, i[7:0], d);
      chk(d, e[i]);
    end
  endtask
  // boundary: d8 is exactly the limit and must not trip
  task automatic t_flags();
    meas_i.drain[0] = 8'hd9;
    meas_i.drain[1] = 8'hd8;
    string_open_i = 4'h2;
    repeat (4) @(negedge sys_clk);
    chk({7'h0, flag}, 8'h01);
    host_u.rd(7'h2c, 8'h05, d);
    chk(d, 8'h22);
  endtask
  // top bits of 05h read back the mask bits, so the checks mask them off
  task automatic t_mask();
    host_u.wr(7'h2c, 8'h05, 8'h80, ack);
    chk({5'h0, ack}, 8'h00);
    chk({7'h0, flag}, 8'h01);
    host_u.rd(7'h2c, 8'h05, d);
    chk(d & 8'h3f, 8'h0a);
    host_u.wr(7'h2c, 8'h05, 8'hc0, ack);
    chk({7'h0, host_u.flag_at_ack}, 8'h00);
    chk({7'h0, flag}, 8'h00);
    host_u.rd(7'h2c, 8'h05, d);
    chk(d & 8'h3f, 8'h09);
  endtask
  task automatic t_ro();
    host_u.wr(7'h2c, 8'h00, 8'hff, ack);
    chk({5'h0, ack}, 8'h00);
    host_u.rd(7'h2c, 8'h00, d);
    chk(d, 8'hd9);
  endtask
  // foreign address carries an unmask; it must be ignored
  task automatic t_addr();
    host_u.wr(7'h2d, 8'h05, 8'h00, ack);
    chk({5'h0, ack}, 8'h07);
    host_u.rd(7'h2c, 8'h05, d);
    chk(d & 8'h3f, 8'h09);
  endtask
  // pointer steps once per byte, both for reads and writes
  task automatic t_word();
    logic [15:0] w;
    logic [3:0]  ack4;
    string_open_i = 4'hc;
    host_u.rd(7'h2c, 8'h06, d);
    chk(d, 8'h12);
    chk({7'h0, flag}, 8'h01);
    host_u.rdw(7'h2c, 8'h00, w);
    chk(w[15:8], 8'hd9);
    chk(w[7:0], 8'hd8);
    host_u.wr2(7'h2c, 8'h05, 8'hc0, 8'hc0, ack4);
    chk({4'h0, ack4}, 8'h00);
    chk({7'h0, flag}, 8'h00);
    host_u.rd(7'h2c, 8'h06, d);
    chk(d & 8'h3f, 8'h09);
  endtask
  task automatic t_strap();
    strap_i = 2'b10;
    do_reset();
    host_u.wr(7'h2f, 8'h05, 8'h00, ack);
    chk({5'h0, ack}, 8'h00);
    host_u.wr(7'h2c, 8'h05, 8'h00, ack);
    chk({5'h0, ack}, 8'h07);
    strap_i = 2'b01;
    do_reset();
    host_u.wr(7'h2e, 8'h05, 8'h00, ack);
    chk({5'h0, ack}, 8'h00);
  endtask
  initial begin
    do_reset();
    t_reset();
    t_meas();
    t_flags();
    t_mask();
    t_ro();
    t_addr();
    t_word();
    t_strap();
    print_verdict();
  end
  initial begin
    #300000;
    err_count++;
    print_verdict();
  end
endmodule
